//--- src/ccr_params.svh
// Offsets, field values and timing constants of the descriptor register bank
`ifndef CCR_PARAMS_SVH
`define CCR_PARAMS_SVH

`define CCR_OFF_OCR          8'h00
`define CCR_OFF_CID0         8'h10
`define CCR_OFF_CSD0         8'h20
`define CCR_OFF_CTRL         8'h30
`define CCR_CTRL_RESTART_BIT 0

`define CCR_OCR_READY_BIT    31
`define CCR_OCR_MODE_SECTOR  2'h2
`define CCR_OCR_RSVD_HI      5'h00
`define CCR_OCR_HIGH_RANGE   9'h1ff
`define CCR_OCR_MID_RANGE    7'h00
`define CCR_OCR_LOW_RANGE    1'h1
`define CCR_OCR_RSVD_LO      7'h00

`define CCR_CRC7_POLY        7'h09
`define CCR_END_BIT          1'h1

`define CCR_CSD_STRUCT       2'h3
`define CCR_CSD_SPEC         4'h4
`define CCR_CSD_READ_ACCESS_TIME_COARSE         8'h4f
`define CCR_CSD_READ_ACCESS_CLOCK_CYCLES         8'h01
`define CCR_CSD_SPEED        8'h32
`define CCR_CSD_CCC          12'h0f5
`define CCR_CSD_RD_BL        4'h9
`define CCR_CSD_WR_BL        4'h9
`define CCR_CSD_SIZE         12'hfff
`define CCR_CSD_CURR         3'h7
`define CCR_CSD_SIZE_MULT    3'h7
`define CCR_CSD_ERASE_GRP    5'h1f
`define CCR_CSD_ERASE_MULT   5'h1f
`define CCR_CSD_WP_GRP       5'h0f
`define CCR_CSD_WP_EN        1'h1
`define CCR_CSD_R2W          3'h2
`define CCR_CSD_CRC          7'h30

`define CCR_CLK_MHZ          20
`define CCR_PWRUP_NS         1000
`define CCR_PWRUP_CYC        ((`CCR_PWRUP_NS * `CCR_CLK_MHZ + 999) / 1000)

`endif

//--- src/ccr_pkg.sv
// Types shared by the descriptor register bank
package ccr_pkg;

	typedef enum logic [0:0] {
		CCR_PWR_BUSY  = 1'b0,
		CCR_PWR_READY = 1'b1
	} ccr_pwr_state_t;

	typedef enum logic [1:0] {
		CCR_RESP_OKAY   = 2'b00,
		CCR_RESP_SLVERR = 2'b10,
		CCR_RESP_DECERR = 2'b11
	} ccr_resp_t;

endpackage

//--- src/ccr_regs.sv
// Descriptor register bank: operating conditions, identification and card-specific data over AXI4-Lite
//
// Overview of operation
// - A 32-bit operating-conditions register is always present and readable.
// - Bit 31 of operating conditions stays low until power-up routine completes.
// - Access mode bits 30:29 read binary 10; bits 28:24 read zero.
// - Voltage window: 23:15 ones, 14:8 zeros, bit 7 one, 6:0 zeros.
// - A 128-bit identification register is provided for the identification phase.
// - Identification holds maker, package type, oem code and 48-bit product name.
// - Identification holds revision, 32-bit serial number and build date.
// - Identification carries CRC7 in bits 7:1 and one in bit 0.
// - Card data structure version 3h, system spec version 4h.
// - Coarse access time 4Fh; clock access time field counts hundreds of cycles.
// - Maximum bus clock code 32h; command class mask F5h in 95:84.
// - Read block length 9h; partial and misaligned access bits read zero.
// - Write block length 9h in 25:22; partial write bit 21 zero.
// - Legacy size FFFh in 73:62; size multiplier 7h in 49:47.
// - Erase group fields 1Fh, protect group 0Fh, protect grouping enabled.
// - Read-to-write factor 2h in 28:26; default ECC zero in 30:29.
// - Copy, permanent and temporary protect flags and file-format fields zero.
// - Driver stage bit 76 zero; all current codes 7h.
// - Card data CRC 30h in bits 7:1 and one in bit 0.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "ccr_params.svh"

module ccr_regs #(
	parameter int          ADDR_W      = 8,
	parameter int          PWRUP_CYC   = `CCR_PWRUP_CYC,
	parameter logic [7:0]  MAKER_CODE  = 8'h5a,            // Arbitrary value
	parameter logic [1:0]  PKG_TYPE    = 2'h2,             // Arbitrary value
	parameter logic [7:0]  OEM_CODE    = 8'h3c,            // Arbitrary value
	parameter logic [47:0] PROD_NAME   = 48'h544553544456, // Arbitrary value
	parameter logic [7:0]  PROD_REV    = 8'h11,            // Arbitrary value
	parameter logic [31:0] SERIAL_NUM  = 32'h00000001,     // Arbitrary value
	parameter logic [7:0]  BUILD_DATE  = 8'h10             // Arbitrary value
) (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
	input  wire logic [2:0]            s_axi_awprot,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output ccr_pkg::ccr_resp_t         s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [ADDR_W-1:0]     s_axi_araddr,
	input  wire logic [2:0]            s_axi_arprot,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output ccr_pkg::ccr_resp_t         s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	output logic                       powerup_done
);
	import ccr_pkg::*;

	function automatic logic [6:0] crc7(input logic [119:0] data);
		logic [6:0] c;
		logic       fb;
		c = 7'h00;
		for (int i = 119; i >= 0; i--) begin
			fb = c[6] ^ data[i];
			c  = {c[5:0], 1'b0};
			if (fb) begin
				c = c ^ `CCR_CRC7_POLY;
			end
		end
		return c;
	endfunction

	// Power-up routine: a fixed settling count, restartable from the control word
	localparam int CNT_W = $clog2(PWRUP_CYC + 1);

	ccr_pwr_state_t   pwr_q;
	ccr_pwr_state_t   pwr_d;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic             restart;

	assign pwr_d = restart ? CCR_PWR_BUSY : ((cnt_q == CNT_W'(PWRUP_CYC - 1)) ? CCR_PWR_READY : pwr_q);
	assign cnt_d = (restart || pwr_q == CCR_PWR_READY) ? '0 : cnt_q + CNT_W'(1);

	always_ff @(posedge clk) begin
		if (rst) begin
			pwr_q <= CCR_PWR_BUSY;
			cnt_q <= '0;
		end else begin
			pwr_q <= pwr_d;
			cnt_q <= cnt_d;
		end
	end

	assign powerup_done = (pwr_q == CCR_PWR_READY);

	// Descriptor images are constants; only the ready flag is live state
	wire [31:0] ocr_img = {powerup_done,
		`CCR_OCR_MODE_SECTOR, `CCR_OCR_RSVD_HI,
		`CCR_OCR_HIGH_RANGE, `CCR_OCR_MID_RANGE,
		`CCR_OCR_LOW_RANGE, `CCR_OCR_RSVD_LO};

	// CRC folds to a constant at elaboration, so no logic is spent on it
	wire [119:0] cid_body = {MAKER_CODE, 6'h00, PKG_TYPE, OEM_CODE, PROD_NAME,
		PROD_REV, SERIAL_NUM, BUILD_DATE};
	wire [127:0] cid_img  = {cid_body, crc7(cid_body), `CCR_END_BIT};

	wire [127:0] csd_img = {
		`CCR_CSD_STRUCT, `CCR_CSD_SPEC, 2'h0,
		`CCR_CSD_READ_ACCESS_TIME_COARSE, `CCR_CSD_READ_ACCESS_CLOCK_CYCLES,
		`CCR_CSD_SPEED, `CCR_CSD_CCC,
		`CCR_CSD_RD_BL, 1'b0, 1'b0, 1'b0,
		1'b0, 2'h0,
		`CCR_CSD_SIZE,
		`CCR_CSD_CURR, `CCR_CSD_CURR, `CCR_CSD_CURR, `CCR_CSD_CURR,
		`CCR_CSD_SIZE_MULT,
		`CCR_CSD_ERASE_GRP, `CCR_CSD_ERASE_MULT, `CCR_CSD_WP_GRP, `CCR_CSD_WP_EN,
		2'h0, `CCR_CSD_R2W,
		`CCR_CSD_WR_BL, 1'b0,
		4'h0, 1'b0, 1'b0,
		1'b0, 1'b0, 1'b0, 2'h0,
		2'h0,
		`CCR_CSD_CRC, `CCR_END_BIT};

	// Write channel: address and data taken in either order, one write at a time
	logic              aw_got_q;
	logic              w_got_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic              wbit_q;
	logic              bvalid_q;
	ccr_resp_t         bresp_q;

	assign s_axi_awready = !aw_got_q && !bvalid_q;
	assign s_axi_wready  = !w_got_q && !bvalid_q;

	wire aw_hs     = s_axi_awvalid && s_axi_awready;
	wire w_hs      = s_axi_wvalid && s_axi_wready;
	wire aw_have   = aw_got_q || aw_hs;
	wire w_have    = w_got_q || w_hs;
	wire wr_fire   = aw_have && w_have;
	wire [ADDR_W-1:0] wa = aw_got_q ? awaddr_q : s_axi_awaddr;
	wire wbit      = w_got_q ? wbit_q : (s_axi_wdata[`CCR_CTRL_RESTART_BIT] && s_axi_wstrb[0]);

	wire wa_ctrl   = (wa == ADDR_W'(`CCR_OFF_CTRL));
	// Descriptor words exist but refuse writes, so software sees its mistake
	wire wa_desc   = (wa == ADDR_W'(`CCR_OFF_OCR)) ||
		(wa[ADDR_W-1:4] == (ADDR_W-4)'(`CCR_OFF_CID0 >> 4)) ||
		(wa[ADDR_W-1:4] == (ADDR_W-4)'(`CCR_OFF_CSD0 >> 4));
	wire [1:0] wr_resp = wa_ctrl ? CCR_RESP_OKAY : (wa_desc ? CCR_RESP_SLVERR : CCR_RESP_DECERR);

	assign restart = wr_fire && wa_ctrl && wbit;

	always_ff @(posedge clk) begin
		if (rst) begin
			aw_got_q <= 1'b0;
			w_got_q  <= 1'b0;
			awaddr_q <= '0;
			wbit_q   <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q  <= CCR_RESP_OKAY;
		end else begin
			aw_got_q <= aw_have && !wr_fire;
			w_got_q  <= w_have && !wr_fire;
			if (aw_hs) begin
				awaddr_q <= s_axi_awaddr;
			end
			if (w_hs) begin
				wbit_q <= s_axi_wdata[`CCR_CTRL_RESTART_BIT] && s_axi_wstrb[0];
			end
			if (wr_fire) begin
				bvalid_q <= 1'b1;
				bresp_q  <= ccr_resp_t'(wr_resp);
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp  = bresp_q;

	// Read channel: one cycle from address acceptance to data
	logic        rvalid_q;
	logic [31:0] rdata_q;
	ccr_resp_t   rresp_q;

	assign s_axi_arready = !rvalid_q;

	wire ar_hs     = s_axi_arvalid && s_axi_arready;
	wire ra_ocr    = (s_axi_araddr == ADDR_W'(`CCR_OFF_OCR));
	wire ra_ctrl   = (s_axi_araddr == ADDR_W'(`CCR_OFF_CTRL));
	wire ra_cid    = (s_axi_araddr[ADDR_W-1:4] == (ADDR_W-4)'(`CCR_OFF_CID0 >> 4)) && (s_axi_araddr[1:0] == 2'h0);
	wire ra_csd    = (s_axi_araddr[ADDR_W-1:4] == (ADDR_W-4)'(`CCR_OFF_CSD0 >> 4)) && (s_axi_araddr[1:0] == 2'h0);
	wire [1:0] rw  = s_axi_araddr[3:2];
	// Word 0 holds the least significant bits of each wide register
	wire [31:0] cid_word = cid_img[32*rw +: 32];
	wire [31:0] csd_word = csd_img[32*rw +: 32];
	wire [31:0] rd_mux   = ra_ocr ? ocr_img : (ra_cid ? cid_word : (ra_csd ? csd_word : 32'h00000000));
	wire [1:0]  rd_resp  = (ra_ocr || ra_cid || ra_csd || ra_ctrl) ? CCR_RESP_OKAY : CCR_RESP_DECERR;

	always_ff @(posedge clk) begin
		if (rst) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h00000000;
			rresp_q  <= CCR_RESP_OKAY;
		end else if (ar_hs) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_mux;
			rresp_q  <= ccr_resp_t'(rd_resp);
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata  = rdata_q;
	assign s_axi_rresp  = rresp_q;

	// Checks
	logic            ar_ocr_q;
	logic            ar_cid0_q;
	logic [ADDR_W-1:0] ar_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			ar_q <= '0;
		end else if (ar_hs) begin
			ar_q <= s_axi_araddr;
		end
	end
	assign ar_ocr_q  = (ar_q == ADDR_W'(`CCR_OFF_OCR));
	assign ar_cid0_q = (ar_q == ADDR_W'(`CCR_OFF_CID0));

	property p_ocr_read;
		@(posedge clk) disable iff (rst)
		s_axi_rvalid && ar_ocr_q |-> s_axi_rdata[30:0] == 31'h40ff8080 && s_axi_rresp == CCR_RESP_OKAY;
	endproperty
	a_ocr_read: assert property (p_ocr_read) else $error("operating conditions word wrong");

	property p_busy_low;
		@(posedge clk) disable iff (rst)
		$rose(powerup_done) |-> $past(cnt_q) == CNT_W'(PWRUP_CYC - 1);
	endproperty
	a_busy_low: assert property (p_busy_low) else $error("ready flag rose early");

	property p_restart_clears;
		@(posedge clk) disable iff (rst)
		restart |=> !powerup_done [*2];
	endproperty
	a_restart_clears: assert property (p_restart_clears) else $error("restart did not clear ready");

	property p_ready_in_time;
		@(posedge clk) disable iff (rst)
		$fell(powerup_done) && !restart |-> ##[1:1000] powerup_done;
	endproperty
	a_ready_in_time: assert property (p_ready_in_time) else $error("power-up never completed");

	property p_ocr_flag_read;
		@(posedge clk) disable iff (rst)
		ar_hs && ra_ocr |=> s_axi_rdata[31] == $past(powerup_done);
	endproperty
	a_ocr_flag_read: assert property (p_ocr_flag_read) else $error("ready flag not reflected");

	property p_cid_end;
		@(posedge clk) disable iff (rst)
		s_axi_rvalid && ar_cid0_q |-> s_axi_rdata[0] == 1'b1 && s_axi_rdata[7:1] == crc7(cid_body);
	endproperty
	a_cid_end: assert property (p_cid_end) else $error("identification crc word wrong");

	property p_csd_top;
		@(posedge clk) disable iff (rst)
		csd_img[127:112] == 16'hd04f && csd_img[95:76] == 20'h0f590;
	endproperty
	a_csd_top: assert property (p_csd_top) else $error("card data top fields wrong");

	property p_csd_mid;
		@(posedge clk) disable iff (rst)
		csd_img[73:47] == 27'h7ffffff && csd_img[46:26] == 21'h1ffbe2;
	endproperty
	a_csd_mid: assert property (p_csd_mid) else $error("card data size or group fields wrong");

	property p_csd_low;
		@(posedge clk) disable iff (rst)
		csd_img[25:0] == 26'h2400061;
	endproperty
	a_csd_low: assert property (p_csd_low) else $error("card data low fields wrong");

	property p_wr_refused;
		@(posedge clk) disable iff (rst)
		wr_fire && wa_desc |=> s_axi_bvalid && s_axi_bresp == CCR_RESP_SLVERR && $stable(csd_img);
	endproperty
	a_wr_refused: assert property (p_wr_refused) else $error("descriptor write not refused");

	property p_read_latency;
		@(posedge clk) disable iff (rst)
		ar_hs |=> s_axi_rvalid;
	endproperty
	a_read_latency: assert property (p_read_latency) else $error("read answer late");

	// A host that stalls ready must still see the same answer later
	property p_rvalid_hold;
		@(posedge clk) disable iff (rst)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
	endproperty
	a_rvalid_hold: assert property (p_rvalid_hold) else $error("read answer dropped before ready");

	property p_bvalid_hold;
		@(posedge clk) disable iff (rst)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bvalid_hold: assert property (p_bvalid_hold) else $error("write answer dropped before ready");

	property p_write_answer;
		@(posedge clk) disable iff (rst)
		wr_fire |=> s_axi_bvalid;
	endproperty
	a_write_answer: assert property (p_write_answer) else $error("write answer late");

	c_ocr_ready_read: cover property (@(posedge clk) disable iff (rst) s_axi_rvalid && ar_ocr_q && s_axi_rdata[31]);
	c_cid_read:       cover property (@(posedge clk) disable iff (rst) s_axi_rvalid && ar_cid0_q);
	c_restart:        cover property (@(posedge clk) disable iff (rst) restart ##[1:40] powerup_done);
	c_desc_write:     cover property (@(posedge clk) disable iff (rst) wr_fire && wa_desc);

endmodule // ccr_regs

//--- dv/ccr_host.sv
// Host-side AXI4-Lite master model for the descriptor bank
`timescale 1ns/100ps

module ccr_host (
	input  wire logic        clk,
	output logic [7:0]       s_axi_awaddr,
	output logic [2:0]       s_axi_awprot,
	output logic             s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic [31:0]      s_axi_wdata,
	output logic [3:0]       s_axi_wstrb,
	output logic             s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output logic             s_axi_bready,
	output logic [7:0]       s_axi_araddr,
	output logic [2:0]       s_axi_arprot,
	output logic             s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output logic             s_axi_rready
);
	initial begin
		{s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_araddr, s_axi_arprot, s_axi_arvalid, s_axi_rready} = '0;
	end

	// Bus values are read right after the edge, before the slave's updates land
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r, output bit ok);
		ok = 1'b0;
		r = 2'h0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int n = 0; n < 100 && !ok; n++) begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~a;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~d;
			end
			if (s_axi_bvalid) begin
				r = s_axi_bresp;
				ok = 1'b1;
				s_axi_bready <= 1'b0;
			end
		end
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r, output bit ok);
		ok = 1'b0;
		d = 32'h0;
		r = 2'h0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int n = 0; n < 100 && !ok; n++) begin
			@(posedge clk);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arvalid <= 1'b0;
				s_axi_araddr <= ~a;
			end
			if (s_axi_rvalid) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				ok = 1'b1;
				s_axi_rready <= 1'b0;
			end
		end
	endtask
endmodule // ccr_host

//--- dv/tb_top.sv
// Self-checking bench for the descriptor register bank
`timescale 1ns/100ps

module tb_top;
	import ccr_pkg::*;

	// Short power-up so that both busy and ready reads fit; identity values are arbitrary
	localparam int          PWR = 8;
	localparam logic [47:0] NAME = 48'h414243444546;
	localparam logic [31:0] SN = 32'h8badf00d;

	logic         clk, rst, powerup_done;
	logic [7:0]   s_axi_awaddr, s_axi_araddr;
	logic [2:0]   s_axi_awprot, s_axi_arprot;
	logic [31:0]  s_axi_wdata, s_axi_rdata;
	logic [3:0]   s_axi_wstrb;
	logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic         s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	ccr_resp_t    s_axi_bresp, s_axi_rresp;
	int           err_total, n_compared, up_cnt, up_last;
	logic [127:0] id_exp, spec_exp;

	ccr_regs #(.PWRUP_CYC(PWR), .MAKER_CODE(8'ha5), .PKG_TYPE(2'h2), .OEM_CODE(8'h6b), .PROD_NAME(NAME),
		.PROD_REV(8'h23), .SERIAL_NUM(SN), .BUILD_DATE(8'h4c)) u_dut (.clk, .rst, .powerup_done,
		.s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

	ccr_host u_host (.clk, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Busy length of the last power-up run, in cycles
	always @(posedge clk) begin
		if (rst) up_cnt <= 0;
		else if (!powerup_done) up_cnt <= up_cnt + 1;
		else if (up_cnt != 0) begin
			up_last <= up_cnt;
			up_cnt <= 0;
		end
	end

	function automatic logic [6:0] crc7(input logic [119:0] m);
		logic [6:0] c;
		c = 7'h00;
		for (int i = 119; i >= 0; i--)
			c = {c[5:0], 1'b0} ^ ((m[i] ^ c[6]) ? 7'h09 : 7'h00);
		return c;
	endfunction

	task automatic end_sim;
		if (err_total == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected data at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected resp at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_flag(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		bit          ok;
		u_host.rd(a, d, r, ok);
		if (!ok) begin
			err_total++;
			end_sim();
		end else begin
			cmp_data(d, ed);
			cmp_resp(r, er);
		end
	endtask

	task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic [1:0] r;
		bit         ok;
		u_host.wr(a, d, r, ok);
		if (!ok) begin
			err_total++;
			end_sim();
		end else
			cmp_resp(r, er);
	endtask

	task automatic rd128(input logic [7:0] base, input logic [127:0] e);
		for (int i = 0; i < 4; i++)
			rd_chk(base + 8'(4 * i), e[32 * i +: 32], CCR_RESP_OKAY);
	endtask

	// The ready flag must come back after roughly the configured busy time
	task automatic wait_done;
		int n;
		n = 0;
		while (powerup_done !== 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		if (n >= 200) begin
			err_total++;
			end_sim();
		end
		@(posedge clk);
		cmp_flag(n < 200 && up_last >= PWR - 1 && up_last <= PWR + 1, 1'b1);
	endtask

	task automatic do_reset(input int n);
		rst <= 1'b1;
		repeat (n) @(posedge clk);
		cmp_flag(powerup_done, 1'b0);
		rst <= 1'b0;
	endtask

	initial begin
		rst = 1'b1;
		err_total = 0;
		n_compared = 0;
		up_last = 0;
		id_exp = {8'ha5, 6'h00, 2'h2, 8'h6b, NAME, 8'h23, SN, 8'h4c, 8'h00};
		id_exp[7:0] = {crc7(id_exp[127:8]), 1'b1};
		spec_exp = {2'h3, 4'h4, 2'h0, 8'h4f, 8'h01, 8'h32, 12'h0f5, 4'h9, 4'h0, 2'h0, 12'hfff, 12'hfff,
			3'h7, 5'h1f, 5'h1f, 5'h0f, 1'h1, 2'h0, 3'h2, 4'h9, 1'h0, 13'h0000, 7'h30, 1'h1};
		do_reset(10);
		rd_chk(8'h00, 32'h40ff8080, CCR_RESP_OKAY);
		wait_done();
		rd_chk(8'h00, 32'hc0ff8080, CCR_RESP_OKAY);
		rd128(8'h10, id_exp);
		rd128(8'h20, spec_exp);
		for (int i = 0; i < 9; i++)
			wr_chk(i == 0 ? 8'h00 : 8'h0c + 8'(4 * i), 32'hffffffff, CCR_RESP_SLVERR);
		rd_chk(8'h00, 32'hc0ff8080, CCR_RESP_OKAY);
		rd128(8'h10, id_exp);
		rd128(8'h20, spec_exp);
		rd_chk(8'h04, 32'h0, CCR_RESP_DECERR);
		rd_chk(8'h40, 32'h0, CCR_RESP_DECERR);
		wr_chk(8'h40, 32'h1, CCR_RESP_DECERR);
		rd_chk(8'h30, 32'h0, CCR_RESP_OKAY);
		wr_chk(8'h30, 32'h1, CCR_RESP_OKAY);
		cmp_flag(powerup_done, 1'b0);
		rd_chk(8'h00, 32'h40ff8080, CCR_RESP_OKAY);
		wait_done();
		do_reset(3);
		rd_chk(8'h00, 32'h40ff8080, CCR_RESP_OKAY);
		wait_done();
		rd_chk(8'h00, 32'hc0ff8080, CCR_RESP_OKAY);
		end_sim();
	end
endmodule // tb_top
